/* File: core/eprg_ctrl.sv */
// eprg_ctrl: host side controller for a byte wide uv eprom, read and program.
// assumes byte_lines arrive from the pins unsynchronised; vpp switch obeys vpp_on.
`timescale 1ns/100ps
module eprg_ctrl
  import eprg_pkg::*;
#(
  parameter int PULSE_CYCLES = PULSE_CYC,
  parameter int MAX_TRIES    = MAX_PULSES
) (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              req,
  input  wire logic              req_write,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_data,
  output eprg_resp_t             resp,
  output logic                   busy,
  output eprg_pins_t             pins,
  input  wire logic [DATA_W-1:0] byte_lines_in,
  output logic [DATA_W-1:0]      byte_lines_out,
  output logic                   byte_lines_oe_n
);
  eprg_state_t       state_reg;
  logic [CNT_W-1:0]  cnt_reg;
  logic [PCNT_W-1:0] tries_reg;
  logic [DATA_W-1:0] sync1_reg;
  logic [DATA_W-1:0] sync2_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic              write_reg;
  logic              verify_ok;
  logic              take_read;
  logic              take_write;
  logic              retry;

  localparam logic [CNT_W-1:0]  C_ACC   = CNT_W'(ACC_CYC);
  localparam logic [CNT_W-1:0]  C_OELAG = CNT_W'(OE_LAG_CYC);
  localparam logic [CNT_W-1:0]  C_OE    = CNT_W'(OE_CYC);
  localparam logic [CNT_W-1:0]  C_FLT   = CNT_W'(FLOAT_CYC);
  localparam logic [CNT_W-1:0]  C_SETUP = CNT_W'(SETUP_CYC);
  localparam logic [CNT_W-1:0]  C_HOLD  = CNT_W'(HOLD_CYC);
  localparam logic [CNT_W-1:0]  C_PULSE = CNT_W'(PULSE_CYCLES);
  localparam logic [PCNT_W-1:0] C_TRIES = PCNT_W'(MAX_TRIES);
  // two extra cycles cover the pin synchroniser on read data
  localparam logic [CNT_W-1:0]  C_SYNC  = CNT_W'(2);

  // only zero bits matter: a one in the request never needs programming
  assign verify_ok = ((sync2_reg | wdata_reg) == wdata_reg) &&
                     ((sync2_reg & ~wdata_reg) == '0);

  // request decode; a request while busy is dropped on purpose
  assign take_read  = (state_reg == EPRG_IDLE) && req && !req_write;
  assign take_write = (state_reg == EPRG_IDLE) && req && req_write;
  // another pulse only while the tries budget lasts
  assign retry      = (state_reg == EPRG_VCHK) && !verify_ok && (tries_reg != C_TRIES);

  // byte_lines_in moves with no regard to clk, so two flops before use
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= byte_lines_in;
      sync2_reg <= sync1_reg;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= EPRG_IDLE;
      cnt_reg   <= '0;
      tries_reg <= '0;
      wdata_reg <= ERASED_BYTE;
      write_reg <= 1'b0;
    end else begin
      // one request at a time; the counter restarts on every state change except roe to rdone
      unique case (state_reg)
        EPRG_IDLE: begin
          // requests seen while busy never reach this state
          cnt_reg   <= '0;
          tries_reg <= '0;
          if (req) begin
            wdata_reg <= req_data;
            write_reg <= req_write;
            state_reg <= req_write ? EPRG_PSET : EPRG_RSEL;
          end
        end
        EPRG_RSEL: begin
          cnt_reg <= cnt_reg + 1'b1;
          // oe falls one lag after select, never later than access minus oe time
          if (cnt_reg == C_OELAG - 1'b1) begin
            cnt_reg   <= '0;
            state_reg <= EPRG_ROE;
          end
        end
        EPRG_ROE: begin
          cnt_reg <= cnt_reg + 1'b1;
          // two extra counts let the synchronised byte settle
          if (cnt_reg == C_OE + C_SYNC) begin
            state_reg <= EPRG_RDONE;
          end
        end
        EPRG_RDONE: begin
          // the response block captures the byte in this state
          cnt_reg   <= '0;
          state_reg <= EPRG_FLOAT;
        end
        EPRG_PSET: begin
          cnt_reg <= cnt_reg + 1'b1;
          // setup plus float time, so a retry still gets full data setup
          if (cnt_reg == C_SETUP + C_FLT) begin
            cnt_reg   <= '0;
            tries_reg <= tries_reg + 1'b1;
            state_reg <= EPRG_PPULSE;
          end
        end
        EPRG_PPULSE: begin
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == C_PULSE - 1'b1) begin
            cnt_reg   <= '0;
            state_reg <= EPRG_PHOLD;
          end
        end
        EPRG_PHOLD: begin
          cnt_reg <= cnt_reg + 1'b1;
          // data stays driven through the hold, then oe falls for verify
          if (cnt_reg == C_HOLD) begin
            cnt_reg   <= '0;
            state_reg <= EPRG_VOE;
          end
        end
        EPRG_VOE: begin
          cnt_reg <= cnt_reg + 1'b1;
          // verify waits the full access time plus the synchroniser
          if (cnt_reg == C_ACC + C_SYNC) begin
            cnt_reg   <= '0;
            state_reg <= EPRG_VCHK;
          end
        end
        EPRG_VCHK: begin
          cnt_reg <= '0;
          // a failed verify with tries left goes round again, vpp still on
          if (!retry) begin
            state_reg <= EPRG_FLOAT;
          end else begin
            state_reg <= EPRG_PSET;
          end
        end
        EPRG_FLOAT: begin
          cnt_reg <= cnt_reg + 1'b1;
          // the part may still drive the lines for the float time after oe rises
          if (cnt_reg == C_FLT) begin
            cnt_reg   <= '0;
            state_reg <= EPRG_IDLE;
          end
        end
        default: state_reg <= EPRG_IDLE;
      endcase
    end
  end

  // pins: select high from reset on, so vpp never rises under a low select
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pins.chip_select_program_n <= 1'b1;
      pins.output_enable_n       <= 1'b1;
      pins.vpp_on                <= 1'b0;
      pins.addr                  <= '0;
      byte_lines_out             <= '0;
      byte_lines_oe_n            <= 1'b1;
    end else begin
      // address and data load once per request and stay put through every retry
      if (take_read || take_write) begin
        pins.addr      <= req_addr;
        byte_lines_out <= req_data;
      end
      // select is per device; oe acts as the shared read strobe
      pins.chip_select_program_n <= !(take_read ||
                                      state_reg == EPRG_RSEL || state_reg == EPRG_ROE ||
                                      state_reg == EPRG_PPULSE);
      pins.output_enable_n <= !(state_reg == EPRG_ROE ||
                                (state_reg == EPRG_RSEL && cnt_reg == C_OELAG - 1'b1) ||
                                (state_reg == EPRG_PHOLD && cnt_reg == C_HOLD) ||
                                state_reg == EPRG_VOE);
      // vpp stays on across retries, so the supply does not cycle per pulse
      pins.vpp_on <= take_write ||
                     state_reg == EPRG_PSET || state_reg == EPRG_PPULSE ||
                     state_reg == EPRG_PHOLD || state_reg == EPRG_VOE ||
                     retry;
      // data drives only while oe is high; on a retry it waits out the float
      // time of the verify read, so the part and the controller never fight
      byte_lines_oe_n <= !(take_write || state_reg == EPRG_PPULSE ||
                           (state_reg == EPRG_PSET && (tries_reg == '0 || cnt_reg >= C_FLT)) ||
                           (state_reg == EPRG_PHOLD && cnt_reg != C_HOLD));
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      resp <= '0;
      busy <= 1'b0;
    end else begin
      busy      <= (state_reg != EPRG_IDLE) || req;
      // done, ok and fail pulse one cycle; data holds to the next done
      resp.done <= 1'b0;
      resp.ok   <= 1'b0;
      resp.fail <= 1'b0;
      if (state_reg == EPRG_RDONE) begin
        resp.done <= 1'b1;
        resp.ok   <= 1'b1;
        resp.data <= sync2_reg;
      end
      if (state_reg == EPRG_VCHK && !retry) begin
        resp.done <= 1'b1;
        resp.ok   <= verify_ok;
        resp.fail <= !verify_ok;
        resp.data <= sync2_reg;
      end
    end
  end
endmodule // eprg_ctrl

/* File: core/eprg_pkg.sv */
// eprg_pkg: constants, states and carriers for the eprom read/program controller.
// assumes a 25 MHz clock; the memory pins are driven through board buffers.
package eprg_pkg;
  localparam int ADDR_W        = 19;
  localparam int DATA_W        = 8;
  localparam int CLK_MHZ       = 25;
  localparam int CLK_NS        = 40;
  localparam int ACC_NS        = 120;   // address_access_delay
  localparam int OE_NS         = 50;    // output_enable_access_delay
  localparam int FLOAT_NS      = 60;
  localparam int SETUP_US      = 1;
  localparam int HOLD_US       = 1;
  localparam int PULSE_US      = 50;
  localparam int MAX_PULSES    = 10;
  // least times round up, pulse width is nominal inside 45..105 us
  localparam int ACC_CYC       = (ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int OE_LAG_CYC    = (ACC_NS - OE_NS) / CLK_NS;
  localparam int OE_CYC        = ACC_CYC - OE_LAG_CYC + 1;
  localparam int FLOAT_CYC     = (FLOAT_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETUP_CYC     = SETUP_US * CLK_MHZ;
  localparam int HOLD_CYC      = HOLD_US * CLK_MHZ;
  localparam int PULSE_CYC     = PULSE_US * CLK_MHZ;
  localparam int CNT_W         = 11;
  localparam int PCNT_W        = 4;
  localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hff;

  typedef enum logic [3:0] {
    EPRG_IDLE   = 4'h0,
    EPRG_RSEL   = 4'h1,
    EPRG_ROE    = 4'h3,
    EPRG_RDONE  = 4'h2,
    EPRG_PSET   = 4'h6,
    EPRG_PPULSE = 4'h7,
    EPRG_PHOLD  = 4'h5,
    EPRG_VOE    = 4'h4,
    EPRG_VCHK   = 4'hc,
    EPRG_FLOAT  = 4'hd
  } eprg_state_t;

  typedef struct packed {
    logic              chip_select_program_n;
    logic              output_enable_n;
    logic              vpp_on;
    logic [ADDR_W-1:0] addr;
  } eprg_pins_t;

  typedef struct packed {
    logic              done;
    logic              ok;
    logic              fail;
    logic [DATA_W-1:0] data;
  } eprg_resp_t;
endpackage

/* File: verif/eprg_ctrl_assertions.sv */
// eprg_ctrl_assertions: pin protocol checks at the controller ports.
// assumes it is bound into eprg_ctrl.
`timescale 1ns/100ps
module eprg_ctrl_assertions
  import eprg_pkg::*;
#(
  parameter int PULSE_CYCLES = PULSE_CYC,
  parameter int MAX_TRIES    = MAX_PULSES
) (
  input wire logic              clk,
  input wire logic              resetn,
  input wire logic              busy,
  input eprg_resp_t             resp,
  input eprg_pins_t             pins,
  input wire logic [DATA_W-1:0] byte_lines_out,
  input wire logic              byte_lines_oe_n
);
  wire               sel_n = pins.chip_select_program_n;
  logic [CNT_W-1:0]  low_reg;
  logic [PCNT_W-1:0] tries_reg;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) low_reg <= '0;
    else low_reg <= (sel_n || !pins.vpp_on) ? '0 : low_reg + 1'b1;
  end
  // retries belong to one request, so clear only when idle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) tries_reg <= '0;
    else if (!busy) tries_reg <= '0;
    else if ($fell(sel_n) && pins.vpp_on) tries_reg <= tries_reg + 1'b1;
  end
  property p_drive; !sel_n && pins.vpp_on |-> !byte_lines_oe_n; endproperty
  a_drive: assert property (p_drive) else $error("byte not driven in pulse");
  property p_steady; !sel_n && pins.vpp_on && $past(!sel_n)
    |-> $stable({pins.addr, byte_lines_out}); endproperty
  a_steady: assert property (p_steady) else $error("inputs moved in pulse");
  property p_width; $rose(sel_n) && pins.vpp_on |-> low_reg == PULSE_CYCLES; endproperty
  a_width: assert property (p_width) else $error("pulse width wrong");
  property p_verify; $rose(sel_n) && pins.vpp_on
    |-> ##[1:40] (!pins.output_enable_n && byte_lines_oe_n); endproperty
  a_verify: assert property (p_verify) else $error("no verify read");
  property p_tries; tries_reg <= MAX_TRIES; endproperty
  a_tries: assert property (p_tries) else $error("too many pulses");
  property p_vpp; $rose(pins.vpp_on) |-> sel_n && $past(sel_n); endproperty
  a_vpp: assert property (p_vpp) else $error("vpp on while selected");
  property p_read; $fell(sel_n) && !pins.vpp_on |=> $fell(pins.output_enable_n); endproperty
  a_read: assert property (p_read) else $error("oe lag wrong");
  property p_fail; resp.fail |-> resp.done && !resp.ok && $past(busy); endproperty
  a_fail: assert property (p_fail) else $error("fail without done");
endmodule // eprg_ctrl_assertions

/* File: verif/eprg_mem_model.sv */
// eprg_mem_model: behavioural eprom of 16 cells, byte lines without pull.
// assumes cell f never programs and cell e needs three pulses.
`timescale 1ns/100ps
module eprg_mem_model
  import eprg_pkg::*;
(
  input wire logic              clk,
  input eprg_pins_t             pins,
  input wire logic [DATA_W-1:0] byte_lines_out,
  input wire logic              byte_lines_oe_n,
  output logic [DATA_W-1:0]     byte_lines_in
);
  logic [DATA_W-1:0] cell_reg [16];
  logic [DATA_W-1:0] last_reg = 8'h00;
  int                hits = 0;
  wire [3:0]         a = pins.addr[3:0];
  wire               drv = !pins.output_enable_n
                           && (!pins.chip_select_program_n || pins.vpp_on);
  initial foreach (cell_reg[i]) cell_reg[i] = ERASED_BYTE;
  always @(posedge pins.chip_select_program_n) begin
    if (pins.vpp_on && pins.output_enable_n && a != 4'hf) begin
      hits = (a == 4'he) ? hits + 1 : 0;
      if (hits % 3 == 0) cell_reg[a] = cell_reg[a] & byte_lines_out;
    end
  end
  // released lines toggle so a stale sample cannot pass
  always @(posedge clk) last_reg <= byte_lines_in;
  assign byte_lines_in = drv ? cell_reg[a] : !byte_lines_oe_n ? byte_lines_out : ~last_reg;
endmodule // eprg_mem_model

/* File: verif/eprg_ctrl_tb_top.sv */
// eprg_ctrl_tb_top: table of reads and writes, then a reset in mid-pulse.
// assumes the model cells e (slow) and f (dead).
`timescale 1ns/100ps
module eprg_ctrl_tb_top
  import eprg_pkg::*;
;
  typedef struct packed {logic w; logic [3:0] a; logic [7:0] d; logic ok; logic [7:0] rd;} eprg_row_t;
  logic              clk = 1'b0, resetn = 1'b0, req = 1'b0, req_write = 1'b0;
  logic [ADDR_W-1:0] req_addr = '0;
  logic [DATA_W-1:0] req_data = '0, byte_lines_in, byte_lines_out;
  logic              byte_lines_oe_n, busy;
  eprg_resp_t        resp, got;
  eprg_pins_t        pins;
  int                fail_count = 0, samples_checked = 0;
  // a one over a stored zero verifies clean: only zero bits are ever asked for
  eprg_row_t         rows [7] = '{'{1'b0, 4'h1, 8'h00, 1'b1, 8'hff},
    '{1'b1, 4'h1, 8'ha5, 1'b1, 8'h00}, '{1'b0, 4'h1, 8'h00, 1'b1, 8'ha5},
    '{1'b1, 4'h1, 8'hff, 1'b1, 8'h00}, '{1'b1, 4'he, 8'h0f, 1'b1, 8'h00},
    '{1'b0, 4'he, 8'h00, 1'b1, 8'h0f}, '{1'b1, 4'hf, 8'h00, 1'b0, 8'h00}};
  always #20 clk = ~clk;
  eprg_ctrl #(.PULSE_CYCLES(8), .MAX_TRIES(10)) i_eprg_ctrl (.clk(clk), .resetn(resetn),
    .req(req), .req_write(req_write), .req_addr(req_addr), .req_data(req_data), .resp(resp),
    .busy(busy), .pins(pins), .byte_lines_in(byte_lines_in), .byte_lines_out(byte_lines_out),
    .byte_lines_oe_n(byte_lines_oe_n));
  eprg_mem_model i_eprg_mem_model (.clk(clk), .pins(pins), .byte_lines_out(byte_lines_out),
    .byte_lines_oe_n(byte_lines_oe_n), .byte_lines_in(byte_lines_in));
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic start(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= 1'b1;
    req_write <= w;
    req_addr <= ADDR_W'(a);
    req_data <= d;
    @(posedge clk);
    req <= 1'b0;
  endtask
  task automatic run(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    start(w, a, d);
    for (n = 0; n < 1000 && resp.done !== 1'b1; n++) @(posedge clk) #1;
    if (n < 1000) begin
      got = resp;
      while (busy !== 1'b0) @(posedge clk) #1;
    end else begin
      // no answer in time: count it and end the simulation here
      fail_count++;
      final_report;
    end
  endtask
  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    foreach (rows[i]) begin
      run(rows[i].w, rows[i].a, rows[i].d);
      chk("ok_fail", {got.ok, got.fail}, {rows[i].ok, !rows[i].ok});
      if (!rows[i].w) chk("data", got.data, rows[i].rd);
    end
    // reset lands inside the first program pulse
    start(1'b1, 4'h3, 8'h00);
    repeat (30) @(posedge clk);
    resetn <= 1'b0;
    #1 chk("reset_pins", {pins.chip_select_program_n, pins.vpp_on, byte_lines_oe_n}, 3'b101);
    @(posedge clk);
    resetn <= 1'b1;
    run(1'b0, 4'h1, 8'h00);
    chk("data_after_reset", got.data, 8'ha5);
    final_report;
  end
  initial begin
    #(40 * 20000);
    fail_count++;
    final_report;
  end
endmodule // eprg_ctrl_tb_top
bind eprg_ctrl eprg_ctrl_assertions #(.PULSE_CYCLES(PULSE_CYCLES), .MAX_TRIES(MAX_TRIES))
  i_eprg_ctrl_assertions (.clk(clk), .resetn(resetn), .busy(busy), .resp(resp), .pins(pins),
  .byte_lines_out(byte_lines_out), .byte_lines_oe_n(byte_lines_oe_n));
